/* pkg/capfuse_pkg.sv */
// Constants and types for the fused capability register bank
package capfuse_pkg;
   localparam int unsigned CFG_AW = 8;
   localparam int unsigned WORD_W = 32;
   // Configuration-space word offsets
   localparam logic [7:0] OFF_CAP0 = 8'h84;
   localparam logic [7:0] OFF_CAP1 = 8'h88;
   localparam logic [7:0] OFF_CAP2 = 8'h8c;
   localparam logic [7:0] OFF_CLK_CFG = 8'hc0;
   localparam logic [7:0] OFF_PERF_CTL = 8'hc4;
   // First capability word
   localparam int unsigned CAP0_UP_BIT = 0;
   localparam int unsigned CAP0_WAY_LO_BIT = 2;
   localparam int unsigned CAP0_WAY_HI_BIT = 3;
   localparam int unsigned CAP0_MT_OFF_BIT = 12;
   // Second capability word
   localparam int unsigned CAP1_FSTEP_OFF_BIT = 4;
   localparam int unsigned CAP1_PWR_OFF_BIT = 5;
   localparam int unsigned CAP1_EXT_IRQ_BIT = 7;
   localparam int unsigned CAP1_PA_LO = 23;
   localparam int unsigned CAP1_PA_HI = 25;
   localparam int unsigned CAP1_MFC_LO = 26;
   localparam int unsigned CAP1_MFC_OC_BIT = 29;
   localparam int unsigned CAP1_MFC_MAX_HI = 28;
   localparam int unsigned CAP1_MIRROR_OFF_BIT = 31;
   // Third capability word
   localparam int unsigned CAP2_WIDE_LO = 1;
   localparam int unsigned CAP2_WIDE_HI = 2;
   localparam int unsigned CAP2_DMA_OFF_BIT = 14;
   localparam int unsigned CAP2_GEN3_OFF_BIT = 15;
   localparam int unsigned CAP2_LINK0_OFF_BIT = 23;
   localparam int unsigned CAP2_LINK1_OFF_BIT = 24;
   localparam int unsigned CAP2_SPD_LO = 25;
   localparam int unsigned CAP2_SPD_HI = 29;
   localparam int unsigned CAP2_LINK2_OFF_BIT = 30;
   // Writable control words
   localparam int unsigned CLK_SEL_LO = 4;
   localparam int unsigned CLK_SEL_HI = 6;
   localparam int unsigned PERF_RATIO_LO = 8;
   localparam int unsigned PERF_RATIO_HI = 15;
   localparam logic [2:0] CLK_SEL_RST = 3'h0;
   localparam logic [7:0] PERF_RATIO_RST = 8'h00;
   // Memory frequency ceilings, lower code is the faster ceiling
   localparam logic [2:0] MF_1333 = 3'h6;
   localparam logic [2:0] MF_1600 = 3'h5;
   localparam logic [2:0] MF_1866 = 3'h4;
   // Physical address size codes and widths
   localparam logic [2:0] PA_CODE_46 = 3'h0;
   localparam logic [2:0] PA_CODE_44 = 3'h2;
   localparam logic [2:0] PA_CODE_36 = 3'h5;
   localparam logic [2:0] PA_CODE_40 = 3'h6;
   localparam logic [5:0] PA_BITS_46 = 6'h2e;
   localparam logic [5:0] PA_BITS_44 = 6'h2c;
   localparam logic [5:0] PA_BITS_36 = 6'h24;
   localparam logic [5:0] PA_BITS_40 = 6'h28;
   localparam logic [5:0] PA_BITS_UNCORE = PA_BITS_44;
   // Cycles spent letting the fuse synchroniser fill after reset
   localparam logic [1:0] FUSE_SETTLE = 2'h3;
   typedef enum logic [1:0] {WAY_1S, WAY_2S, WAY_4S, WAY_8S} wayness_t;
   typedef enum logic [1:0] {ST_SYNC, ST_LOAD, ST_READY} fuse_st_t;
endpackage

/* pkg/cap_if.sv */
// Carrier between the capability store and its field decoder
`timescale 1ns/10ps
interface cap_if;
   logic [31:0] cap0;
   logic [31:0] cap1;
   logic [31:0] cap2;
   logic [1:0] wayness;
   logic [5:0] pa_bits;
   logic [2:0] link_on;
   logic wide_limit;
   logic overclock;
   logic [7:0] sel_ok;
   modport src (output cap0, cap1, cap2,
      input wayness, pa_bits, link_on, wide_limit, overclock, sel_ok);
   modport dec (input cap0, cap1, cap2,
      output wayness, pa_bits, link_on, wide_limit, overclock, sel_ok);
endinterface

/* hw/cap_field_decode.sv */
// Field decoder for the fused capability words
`timescale 1ns/10ps
module cap_field_decode
   import capfuse_pkg::*;
(
   cap_if.dec c
);
   logic [2:0] mf_max;
   logic mf_legal;

   assign c.wayness = {c.cap0[CAP0_WAY_HI_BIT], c.cap0[CAP0_WAY_LO_BIT]};
   assign c.overclock = c.cap1[CAP1_MFC_OC_BIT];
   assign mf_max = c.cap1[CAP1_MFC_MAX_HI:CAP1_MFC_LO];
   // Reserved ceilings admit no select value unless the overclock bit is set
   assign mf_legal = (mf_max == MF_1333) || (mf_max == MF_1600) ||
      (mf_max == MF_1866);
   assign c.link_on = ~{c.cap2[CAP2_LINK2_OFF_BIT],
      c.cap2[CAP2_LINK1_OFF_BIT], c.cap2[CAP2_LINK0_OFF_BIT]};
   assign c.wide_limit = |c.cap2[CAP2_WIDE_HI:CAP2_WIDE_LO];

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_sel
         localparam logic [2:0] CODE = 3'(g);
         assign c.sel_ok[g] = c.overclock ||
            (mf_legal && CODE >= mf_max && CODE <= MF_1333);
      end
   endgenerate

   always_comb begin
      unique case (c.cap1[CAP1_PA_HI:CAP1_PA_LO])
         PA_CODE_46: c.pa_bits = PA_BITS_46;
         PA_CODE_44: c.pa_bits = PA_BITS_44;
         PA_CODE_36: c.pa_bits = PA_BITS_36;
         PA_CODE_40: c.pa_bits = PA_BITS_40;
         default: c.pa_bits = PA_BITS_UNCORE;
      endcase
   end
endmodule

/* hw/sku_capability_fuse_regs.sv */
// Fused capability register bank with the controls it gates
`timescale 1ns/10ps
module sku_capability_fuse_regs
   import capfuse_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [31:0] fuse_cap0_in,
   input wire logic [31:0] fuse_cap1_in,
   input wire logic [31:0] fuse_cap2_in,
   input wire logic cfg_req_in,
   input wire logic cfg_we_in,
   input wire logic [7:0] cfg_addr_in,
   input wire logic [31:0] cfg_wdata_in,
   output logic cfg_ack_out,
   output logic [31:0] cfg_rdata_out,
   output logic write_refused_out,
   output logic fuse_ready_out,
   output logic [1:0] socket_wayness_out,
   output logic uniprocessor_variant_out,
   output logic multithread_off_out,
   output logic mirroring_active_out,
   output logic [5:0] core_pa_bits_out,
   output logic power_gating_on_out,
   output logic ext_irq_ctrl_mode_on_out,
   output logic [2:0] coherent_link_on_out,
   output logic [4:0] link_speed_allowed_out,
   output logic wide_port_limit_out,
   output logic gen3_signalling_off_out,
   output logic dma_engine_off_out,
   output logic [2:0] mem_freq_sel_out,
   output logic [7:0] perf_ratio_out
);
   cap_if cif ();
   cap_field_decode u_decode (.c(cif));

   logic [31:0] meta0_q, meta1_q, meta2_q;
   logic [31:0] sync0_q, sync1_q, sync2_q;
   logic [31:0] cap0_q, cap1_q, cap2_q;
   fuse_st_t state_q;
   logic [1:0] settle_q;
   logic rd_hit, wr_hit;
   logic [2:0] sel_wr;
   logic [7:0] ratio_wr;
   logic sel_refuse, perf_refuse;
   logic [31:0] rdata_d;

   assign cif.cap0 = cap0_q;
   assign cif.cap1 = cap1_q;
   assign cif.cap2 = cap2_q;

   // Fuse levels come from outside this clock, two flops before use
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta0_q <= '0;
         meta1_q <= '0;
         meta2_q <= '0;
         sync0_q <= '0;
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (ce_in) begin
         meta0_q <= fuse_cap0_in;
         meta1_q <= fuse_cap1_in;
         meta2_q <= fuse_cap2_in;
         sync0_q <= meta0_q;
         sync1_q <= meta1_q;
         sync2_q <= meta2_q;
      end
   end

   // Fuses are caught once after reset; later pin noise cannot alter them
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ST_SYNC;
         settle_q <= '0;
      end else if (ce_in) begin
         unique case (state_q)
            ST_SYNC: begin
               if (settle_q == FUSE_SETTLE) begin
                  state_q <= ST_LOAD;
               end else begin
                  settle_q <= settle_q + 2'h1;
               end
            end
            ST_LOAD: state_q <= ST_READY;
            ST_READY: state_q <= ST_READY;
            default: state_q <= ST_SYNC;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cap0_q <= '0;
         cap1_q <= '0;
         cap2_q <= '0;
      end else if (ce_in && state_q == ST_LOAD) begin
         cap0_q <= sync0_q;
         cap1_q <= sync1_q;
         cap2_q <= sync2_q;
      end
   end

   // Decoded controls lag the words by a cycle, so ready does as well
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fuse_ready_out <= 1'b0;
         socket_wayness_out <= WAY_1S;
         uniprocessor_variant_out <= 1'b0;
         multithread_off_out <= 1'b0;
         mirroring_active_out <= 1'b0;
         core_pa_bits_out <= PA_BITS_UNCORE;
         power_gating_on_out <= 1'b0;
         ext_irq_ctrl_mode_on_out <= 1'b0;
         coherent_link_on_out <= '0;
         link_speed_allowed_out <= '0;
         wide_port_limit_out <= 1'b0;
         gen3_signalling_off_out <= 1'b0;
         dma_engine_off_out <= 1'b0;
      end else if (ce_in) begin
         fuse_ready_out <= (state_q == ST_READY);
         socket_wayness_out <= cif.wayness;
         uniprocessor_variant_out <= cap0_q[CAP0_UP_BIT];
         multithread_off_out <= cap0_q[CAP0_MT_OFF_BIT];
         mirroring_active_out <= ~cap1_q[CAP1_MIRROR_OFF_BIT];
         core_pa_bits_out <= cif.pa_bits;
         power_gating_on_out <= ~cap1_q[CAP1_PWR_OFF_BIT];
         ext_irq_ctrl_mode_on_out <= cap1_q[CAP1_EXT_IRQ_BIT];
         coherent_link_on_out <= cif.link_on;
         link_speed_allowed_out <= cap2_q[CAP2_SPD_HI:CAP2_SPD_LO];
         wide_port_limit_out <= cif.wide_limit;
         gen3_signalling_off_out <= cap2_q[CAP2_GEN3_OFF_BIT];
         dma_engine_off_out <= cap2_q[CAP2_DMA_OFF_BIT];
      end
   end

   assign rd_hit = ce_in && cfg_req_in && !cfg_we_in;
   assign wr_hit = ce_in && cfg_req_in && cfg_we_in;
   assign sel_wr = cfg_wdata_in[CLK_SEL_HI:CLK_SEL_LO];
   assign ratio_wr = cfg_wdata_in[PERF_RATIO_HI:PERF_RATIO_LO];
   // Writes before the fuses are known are refused to stay safe
   assign sel_refuse = !fuse_ready_out || !cif.sel_ok[sel_wr];
   assign perf_refuse = !fuse_ready_out ||
      (cap1_q[CAP1_FSTEP_OFF_BIT] && ratio_wr != perf_ratio_out);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_freq_sel_out <= CLK_SEL_RST;
      end else if (wr_hit && cfg_addr_in == OFF_CLK_CFG && !sel_refuse) begin
         mem_freq_sel_out <= sel_wr;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         perf_ratio_out <= PERF_RATIO_RST;
      end else if (wr_hit && cfg_addr_in == OFF_PERF_CTL && !perf_refuse) begin
         perf_ratio_out <= ratio_wr;
      end
   end

   always_comb begin
      rdata_d = '0;
      unique case (cfg_addr_in)
         OFF_CAP0: rdata_d = cap0_q;
         OFF_CAP1: rdata_d = cap1_q;
         OFF_CAP2: rdata_d = cap2_q;
         OFF_CLK_CFG: rdata_d[CLK_SEL_HI:CLK_SEL_LO] = mem_freq_sel_out;
         OFF_PERF_CTL: rdata_d[PERF_RATIO_HI:PERF_RATIO_LO] = perf_ratio_out;
         default: rdata_d = '0;
      endcase
   end

   // Every access is answered one cycle later; capability writes are dropped
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_ack_out <= 1'b0;
         cfg_rdata_out <= '0;
         write_refused_out <= 1'b0;
      end else if (ce_in) begin
         cfg_ack_out <= cfg_req_in;
         if (rd_hit) begin
            cfg_rdata_out <= rdata_d;
         end
         write_refused_out <= wr_hit && (
            (cfg_addr_in == OFF_CLK_CFG && sel_refuse) ||
            (cfg_addr_in == OFF_PERF_CTL && perf_refuse));
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   AST_CAP_WRITE_IGNORED: assert property (
      wr_hit && fuse_ready_out && (cfg_addr_in == OFF_CAP0 ||
      cfg_addr_in == OFF_CAP1 || cfg_addr_in == OFF_CAP2)
      |=> $stable(cap0_q) && $stable(cap1_q) && $stable(cap2_q))
      else $error("capability word changed by a write");

   AST_CAP_READ: assert property (
      rd_hit && cfg_addr_in == OFF_CAP1
      |=> cfg_ack_out && cfg_rdata_out == $past(cap1_q))
      else $error("capability read returned wrong word");

   AST_WAYNESS: assert property (
      fuse_ready_out |-> socket_wayness_out ==
      {cap0_q[CAP0_WAY_HI_BIT], cap0_q[CAP0_WAY_LO_BIT]})
      else $error("socket wayness differs from fuse bits");

   AST_UP_MT: assert property (
      fuse_ready_out |-> uniprocessor_variant_out == cap0_q[CAP0_UP_BIT] &&
      multithread_off_out == cap0_q[CAP0_MT_OFF_BIT])
      else $error("uniprocessor or thread flag wrong");

   AST_FREQ_REFUSED: assert property (
      wr_hit && cfg_addr_in == OFF_CLK_CFG && fuse_ready_out &&
      !cap1_q[CAP1_MFC_OC_BIT] && sel_wr < cap1_q[CAP1_MFC_MAX_HI:CAP1_MFC_LO]
      |=> $stable(mem_freq_sel_out) && write_refused_out)
      else $error("unsupported frequency select accepted");

   AST_FREQ_OVERCLOCK: assert property (
      wr_hit && cfg_addr_in == OFF_CLK_CFG && fuse_ready_out &&
      cap1_q[CAP1_MFC_OC_BIT] |=> mem_freq_sel_out == $past(sel_wr))
      else $error("overclock part refused a select");

   AST_PA_BITS: assert property (
      fuse_ready_out && cap1_q[CAP1_PA_HI:CAP1_PA_LO] == PA_CODE_36
      |-> core_pa_bits_out == PA_BITS_36)
      else $error("address width decode wrong");

   AST_MIRROR_POWER: assert property (
      fuse_ready_out |-> mirroring_active_out != cap1_q[CAP1_MIRROR_OFF_BIT]
      && power_gating_on_out != cap1_q[CAP1_PWR_OFF_BIT])
      else $error("mirroring or power feature state wrong");

   AST_RATIO_LOCK: assert property (
      wr_hit && cfg_addr_in == OFF_PERF_CTL && cap1_q[CAP1_FSTEP_OFF_BIT]
      |=> $stable(perf_ratio_out))
      else $error("core ratio changed while stepping is off");

   AST_LINKS: assert property (
      fuse_ready_out |-> coherent_link_on_out[2] != cap2_q[CAP2_LINK2_OFF_BIT]
      && coherent_link_on_out[0] != cap2_q[CAP2_LINK0_OFF_BIT]
      && ext_irq_ctrl_mode_on_out == cap1_q[CAP1_EXT_IRQ_BIT])
      else $error("link enable or irq mode wrong");

   AST_PCIE_FIELDS: assert property (
      fuse_ready_out |-> wide_port_limit_out ==
      (cap2_q[CAP2_WIDE_HI:CAP2_WIDE_LO] != 2'h0) &&
      dma_engine_off_out == cap2_q[CAP2_DMA_OFF_BIT] &&
      link_speed_allowed_out == cap2_q[CAP2_SPD_HI:CAP2_SPD_LO])
      else $error("port limit or speed field wrong");

   AST_READY_TIME: assert property (
      $rose(rst_n_in) ##0 ce_in [*6] |=> fuse_ready_out)
      else $error("fuses not ready seven cycles after reset");

   // A lost ack would hang the caller, so every taken request is answered
   AST_ACK_ONE_CYCLE: assert property (
      ce_in && cfg_req_in |=> cfg_ack_out)
      else $error("request not acknowledged");

   AST_ACK_PULSE: assert property (
      ce_in && !cfg_req_in |=> !cfg_ack_out)
      else $error("acknowledge without a request");

   AST_EARLY_REFUSE: assert property (
      wr_hit && !fuse_ready_out && cfg_addr_in == OFF_CLK_CFG
      |=> write_refused_out && $stable(mem_freq_sel_out))
      else $error("select accepted before fuses were ready");

   AST_CAP_HOLD: assert property (
      fuse_ready_out |=> $stable(cap0_q) && $stable(cap1_q) &&
      $stable(cap2_q))
      else $error("capability word moved after capture");

   AST_GEN3_LINK1: assert property (
      fuse_ready_out |-> gen3_signalling_off_out == cap2_q[CAP2_GEN3_OFF_BIT]
      && coherent_link_on_out[1] != cap2_q[CAP2_LINK1_OFF_BIT])
      else $error("gen3 or link 1 state wrong");

   COV_READ_CAP0: cover property (rd_hit && cfg_addr_in == OFF_CAP0);
   COV_FREQ_REFUSED: cover property (write_refused_out);
   COV_RATIO_WRITE: cover property (
      wr_hit && cfg_addr_in == OFF_PERF_CTL && !perf_refuse);
   COV_OVERCLOCK: cover property (fuse_ready_out && cif.overclock);
   COV_EIGHT_SOCKET: cover property (
      fuse_ready_out && socket_wayness_out == WAY_8S);
endmodule

/* tb/sku_capability_fuse_regs_test.sv */
// Self-checking bench for the fused capability register bank
`timescale 1ns/10ps
module sku_capability_fuse_regs_test;
   import capfuse_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce_in = 1'b1;
   logic [31:0] fuse_cap0_in = 32'h0;
   logic [31:0] fuse_cap1_in = 32'h0;
   logic [31:0] fuse_cap2_in = 32'h0;
   logic cfg_req_in = 1'b0;
   logic cfg_we_in = 1'b0;
   logic [7:0] cfg_addr_in = 8'h0;
   logic [31:0] cfg_wdata_in = 32'h0;
   logic cfg_ack_out, write_refused_out, fuse_ready_out;
   logic [31:0] cfg_rdata_out;
   logic [1:0] socket_wayness_out;
   logic uniprocessor_variant_out, multithread_off_out, mirroring_active_out;
   logic [5:0] core_pa_bits_out;
   logic power_gating_on_out, ext_irq_ctrl_mode_on_out;
   logic [2:0] coherent_link_on_out;
   logic [4:0] link_speed_allowed_out;
   logic wide_port_limit_out, gen3_signalling_off_out, dma_engine_off_out;
   logic [2:0] mem_freq_sel_out;
   logic [7:0] perf_ratio_out;
   int tests_run = 0;
   int bad_count = 0;
   integer seed = 39;
   int n, r, i, k;
   logic [31:0] f [3];
   logic [31:0] wd, rd;
   logic rf, ok;
   logic [2:0] s, exp_sel;
   logic [7:0] rt, exp_ratio;
   logic [7:0] offs [3] = '{OFF_CAP0, OFF_CAP1, OFF_CAP2};
   // Overclock, each ceiling, reserved ceilings
   logic [3:0] mfc_tab [8] = '{4'h8, 4'h6, 4'h5, 4'h4, 4'h0, 4'h7, 4'he, 4'h3};

   sku_capability_fuse_regs sku_capability_fuse_regs_i (.clk_in, .rst_n_in,
      .ce_in, .fuse_cap0_in, .fuse_cap1_in, .fuse_cap2_in, .cfg_req_in,
      .cfg_we_in, .cfg_addr_in, .cfg_wdata_in, .cfg_ack_out, .cfg_rdata_out,
      .write_refused_out, .fuse_ready_out, .socket_wayness_out,
      .uniprocessor_variant_out, .multithread_off_out, .mirroring_active_out,
      .core_pa_bits_out, .power_gating_on_out, .ext_irq_ctrl_mode_on_out,
      .coherent_link_on_out, .link_speed_allowed_out, .wide_port_limit_out,
      .gen3_signalling_off_out, .dma_engine_off_out, .mem_freq_sel_out,
      .perf_ratio_out);

   always #5 clk_in = ~clk_in;

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [5:0] exp_pa(input logic [2:0] c);
      case (c)
         3'h0: exp_pa = 6'h2e;
         3'h2: exp_pa = 6'h2c;
         3'h5: exp_pa = 6'h24;
         3'h6: exp_pa = 6'h28;
         default: exp_pa = 6'h2c;
      endcase
   endfunction

   // Reserved ceilings accept no select unless the overclock bit is set
   function automatic logic sel_ok(input logic [31:0] c1,
         input logic [2:0] sl);
      logic [2:0] m;
      m = c1[28:26];
      if (c1[29]) begin
         sel_ok = 1'b1;
      end else begin
         sel_ok = m >= 3'h4 && m <= 3'h6 && sl >= m && sl <= 3'h6;
      end
   endfunction

   // One access; the ack is looked for on falling edges under a bound
   task automatic cfg(input logic we, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic rfu);
      int w;
      @(negedge clk_in);
      cfg_req_in = 1'b1;
      cfg_we_in = we;
      cfg_addr_in = a;
      cfg_wdata_in = d;
      @(negedge clk_in);
      cfg_req_in = 1'b0;
      w = 0;
      while (cfg_ack_out !== 1'b1 && w < 4) begin
         @(negedge clk_in);
         w++;
      end
      if (cfg_ack_out !== 1'b1) begin
         bad_count++;
         $display("[FAIL] cfg_ack_out expected 1 seen none");
         tally_and_finish();
      end
      q = cfg_rdata_out;
      rfu = write_refused_out;
   endtask

   // Fuses change only while reset is held, as capture happens once
   task automatic do_reset();
      @(negedge clk_in);
      rst_n_in = 1'b0;
      fuse_cap0_in = f[0];
      fuse_cap1_in = f[1];
      fuse_cap2_in = f[2];
      repeat (10) @(negedge clk_in);
      chk("pa_bits_in_reset", core_pa_bits_out, 6'h2c);
      chk("ready_in_reset", fuse_ready_out, 1'b0);
      chk("sel_in_reset", mem_freq_sel_out, CLK_SEL_RST);
      rst_n_in = 1'b1;
      exp_sel = CLK_SEL_RST;
      exp_ratio = PERF_RATIO_RST;
   endtask

   initial begin
      for (r = 0; r < 8; r++) begin
         f[0] = $random(seed);
         f[0][3:2] = r[1:0];
         f[1] = $random(seed);
         f[1][29:26] = mfc_tab[r];
         f[1][25:23] = r[2:0];
         f[1][4] = r[0];
         f[2] = $random(seed);
         do_reset();
         cfg(1'b1, OFF_CLK_CFG, 32'h60, rd, rf);
         chk("early_write_refused", rf, 1'b1);
         n = 0;
         while (fuse_ready_out !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
         end
         if (fuse_ready_out !== 1'b1) begin
            bad_count++;
            $display("[FAIL] fuse_ready_out expected 1 seen 0");
            tally_and_finish();
         end
         chk("wayness", socket_wayness_out, f[0][3:2]);
         chk("uniproc", uniprocessor_variant_out, f[0][0]);
         chk("mt_off", multithread_off_out, f[0][12]);
         chk("mirror", mirroring_active_out, !f[1][31]);
         chk("pa_bits", core_pa_bits_out, exp_pa(f[1][25:23]));
         chk("pwr_gate", power_gating_on_out, !f[1][5]);
         chk("ext_irq", ext_irq_ctrl_mode_on_out, f[1][7]);
         chk("links", coherent_link_on_out,
            {f[2][30], f[2][24], f[2][23]} ^ 3'h7);
         chk("speed", link_speed_allowed_out, f[2][29:25]);
         chk("wide", wide_port_limit_out, |f[2][2:1]);
         chk("gen3", gen3_signalling_off_out, f[2][15]);
         chk("dma", dma_engine_off_out, f[2][14]);
         for (i = 0; i < 3; i++) begin
            cfg(1'b1, offs[i], $random(seed), rd, rf);
            chk("cap_write_pulse", rf, 1'b0);
            cfg(1'b0, offs[i], 32'h0, rd, rf);
            chk("cap_read", rd, f[i]);
         end
         cfg(1'b0, 8'h40, 32'h0, rd, rf);
         chk("unmapped_read", rd, 32'h0);
         cfg(1'b1, 8'h44, $random(seed), rd, rf);
         chk("unmapped_write", rf, 1'b0);
         for (k = 0; k < 8; k++) begin
            s = 3'((k * 5 + r) % 8);
            wd = $random(seed);
            wd[6:4] = s;
            ok = sel_ok(f[1], s);
            cfg(1'b1, OFF_CLK_CFG, wd, rd, rf);
            if (ok) begin
               exp_sel = s;
            end
            chk("sel_refused", rf, !ok);
            chk("sel_value", mem_freq_sel_out, exp_sel);
         end
         cfg(1'b0, OFF_CLK_CFG, 32'h0, rd, rf);
         chk("sel_read", rd, {25'h0, exp_sel, 4'h0});
         for (k = 0; k < 4; k++) begin
            wd = $random(seed);
            rt = (k == 1) ? exp_ratio : wd[15:8];
            wd[15:8] = rt;
            ok = !f[1][4] || rt == exp_ratio;
            cfg(1'b1, OFF_PERF_CTL, wd, rd, rf);
            if (ok) begin
               exp_ratio = rt;
            end
            chk("ratio_refused", rf, !ok);
            chk("ratio_value", perf_ratio_out, exp_ratio);
         end
         cfg(1'b0, OFF_PERF_CTL, 32'h0, rd, rf);
         chk("ratio_read", rd, {16'h0, exp_ratio, 8'h0});
         // A request while the clock enable is low must not be taken
         @(negedge clk_in);
         ce_in = 1'b0;
         cfg_req_in = 1'b1;
         cfg_we_in = 1'b0;
         repeat (2) @(negedge clk_in);
         chk("ack_while_frozen", cfg_ack_out, 1'b0);
         cfg_req_in = 1'b0;
         ce_in = 1'b1;
         repeat (2) @(negedge clk_in);
         chk("ack_ce_low", cfg_ack_out, 1'b0);
         $display("Round %0d done, mismatches so far %0d", r, bad_count);
      end
      tally_and_finish();
   end
endmodule
